// ---- rtl/code_protection_defs.vh ----
// Constants shared by the code protection unit and its region decoder
`ifndef CODE_PROTECTION_DEFS_VH
`define CODE_PROTECTION_DEFS_VH
`define ADDR_W 21
`define NUM_REGIONS 5
`define BOOT_END 21'h0007ff
`define BLK0_END 21'h001fff
`define BLK1_END 21'h003fff
`define BLK2_END 21'h005fff
`define BLK3_END 21'h007fff
`define ID_FIRST 21'h200000
`define ID_LAST 21'h200007
`define CFG_FIRST 21'h300000
`define CFG_LAST 21'h3000ff
`define DEVID_FIRST 21'h3ffffe
`define REGION_NONE 3'h7
`define GUARDS_RESET 5'h1f
`define GUARD_BIT_RESET 1'b1
`define LVP_RESET 1'b1
`define DEBUG_RESET 1'b1
`endif

// ---- rtl/region_decoder.v ----
// Maps a program memory address onto its protection region
`timescale 1ns/1ns
`default_nettype none
`include "code_protection_defs.vh"
module region_decoder (
  input wire [20:0] addr_i,
  output reg [2:0] region_o
);
  // Pure decode so guards apply in the access cycle itself
  always @*
  begin
    if (addr_i <= `BOOT_END)
      region_o = 3'h0;
    else if (addr_i <= `BLK0_END)
      region_o = 3'h1;
    else if (addr_i <= `BLK1_END)
      region_o = 3'h2;
    else if (addr_i <= `BLK2_END)
      region_o = 3'h3;
    else if (addr_i <= `BLK3_END)
      region_o = 3'h4;
    else
      region_o = `REGION_NONE;
  end
endmodule // region_decoder
`default_nettype wire

// ---- rtl/code_protection_unit.v ----
// Access gating for program memory, data EEPROM, config and ID space
`timescale 1ns/1ns
`default_nettype none
`include "code_protection_defs.vh"
module code_protection_unit (
  input wire clk_sys_i,
  input wire rst_i,
  // Core table access
  input wire tbl_rd_i,
  input wire tbl_wr_i,
  input wire [20:0] tbl_addr_i,
  input wire [20:0] exec_pc_i,
  input wire [7:0] mem_rdata_i,
  // External programmer access
  input wire ext_rd_i,
  input wire ext_wr_i,
  input wire [20:0] ext_addr_i,
  input wire ext_eeprom_i,
  input wire ext_chip_erase_i,
  input wire ext_block_erase_i,
  input wire [4:0] ext_erase_blocks_i,
  input wire ext_row_erase_i,
  // Guard bit writes (core table write or programmer), 1 = bit to clear; low-voltage enable and debug values are written as given
  input wire guard_wr_ext_i,
  input wire guard_wr_core_i,
  input wire [4:0] wr_read_guard_i,
  input wire [4:0] wr_write_guard_i,
  input wire [4:0] wr_table_read_guard_i,
  input wire [2:0] wr_misc_i,
  input wire wr_lvp_i,
  input wire wr_lvp_val_i,
  input wire wr_debug_i,
  input wire wr_debug_val_i,
  // Core EEPROM access
  input wire core_ee_rd_i,
  input wire core_ee_wr_i,
  // Entry pins (asynchronous)
  input wire master_clear_hv_i,
  input wire program_entry_pin_i,
  // Results
  output reg tbl_rd_ok_o,
  output reg [7:0] tbl_rdata_o,
  output reg tbl_wr_ok_o,
  output reg ext_rd_ok_o,
  output reg ext_wr_ok_o,
  output reg core_ee_rd_ok_o,
  output reg core_ee_wr_ok_o,
  output reg erase_ok_o,
  output reg prog_mode_o,
  output reg hv_mode_o,
  output reg pgm_pin_dedicated_o,
  output reg debug_enable_o,
  output reg [4:0] block_read_guard_o,
  output reg [4:0] block_write_guard_o,
  output reg [4:0] block_table_read_guard_o,
  output reg eeprom_read_guard_o,
  output reg eeprom_write_guard_o,
  output reg config_write_guard_o
);
  // Stored protection state; a 1 leaves the guarded space open
  wire [4:0] block_read_guard;
  wire [4:0] block_write_guard;
  wire [4:0] block_table_read_guard;
  reg eeprom_read_guard;
  reg eeprom_write_guard;
  reg config_write_guard;
  reg low_voltage_prog_enable;
  reg debug_bit;
  reg [1:0] hv_sync;
  reg [1:0] pgm_sync;

  // Decoded address facts and the permissions built from them
  wire [2:0] tbl_region;
  wire [2:0] pc_region;
  wire [2:0] ext_region;
  wire tbl_in_prog;
  wire tbl_is_id;
  wire tbl_is_cfg;
  wire tbl_is_dev;
  wire ext_in_prog;
  wire tbl_rd_allow;
  wire tbl_wr_allow;
  wire ext_allow;
  wire ext_wr_allow;
  wire hv_now;
  wire lv_now;
  wire erase_req;
  wire erase_allow;
  wire row_blocked;
  wire guard_wr_ext_ok;
  wire guard_wr_core_ok;
  wire guard_write_ok;
  wire erase_go;

  // One decoder per address that can land in a region
  region_decoder u_tbl_dec (
    .addr_i(tbl_addr_i),
    .region_o(tbl_region)
  );
  region_decoder u_pc_dec (
    .addr_i(exec_pc_i),
    .region_o(pc_region)
  );
  region_decoder u_ext_dec (
    .addr_i(ext_addr_i),
    .region_o(ext_region)
  );

  // Two-stage synchronisers for the entry pins
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hv_sync <= 2'h0;
      pgm_sync <= 2'h0;
    end
    else
    begin
      hv_sync <= {hv_sync[0], master_clear_hv_i};
      pgm_sync <= {pgm_sync[0], program_entry_pin_i};
    end
  end

  // High voltage always wins; low voltage only when enabled
  assign hv_now = hv_sync[1];
  assign lv_now = low_voltage_prog_enable & pgm_sync[1];

  // Address classes
  assign tbl_in_prog = (tbl_region != `REGION_NONE);
  assign tbl_is_id = (tbl_addr_i >= `ID_FIRST) && (tbl_addr_i <= `ID_LAST);
  assign tbl_is_cfg = (tbl_addr_i >= `CFG_FIRST) && (tbl_addr_i <= `CFG_LAST);
  assign tbl_is_dev = (tbl_addr_i >= `DEVID_FIRST);
  assign ext_in_prog = (ext_region != `REGION_NONE);

  // Table read: refused only outside-block reads of guarded blocks
  // Region 7 never indexes the guards: the region test short-circuits first
  assign tbl_rd_allow = !tbl_in_prog || (tbl_region == pc_region) ||
    block_table_read_guard[tbl_region];

  // Table write: program blocks by write guard, config by its guard
  assign tbl_wr_allow = tbl_in_prog ? block_write_guard[tbl_region] :
    (tbl_is_cfg ? config_write_guard : !tbl_is_dev);

  // External access: read guard per block or EEPROM guard
  assign ext_allow = ext_eeprom_i ? eeprom_read_guard :
    (!ext_in_prog || block_read_guard[ext_region]);
  assign ext_wr_allow = ext_allow && (ext_eeprom_i ? eeprom_write_guard :
    (!ext_in_prog || block_write_guard[ext_region]));

  // Erase only from programmer in programming mode
  assign erase_req = ext_chip_erase_i | ext_block_erase_i;
  assign erase_allow = prog_mode_o;
  // Row erase is refused on a target block whose read or write guard is clear
  assign row_blocked = ext_in_prog && (!block_read_guard[ext_region] ||
    !block_write_guard[ext_region]);

  // Who may write guards now; the core is shut out once the config guard is 0
  assign guard_wr_ext_ok = guard_wr_ext_i && prog_mode_o;
  assign guard_wr_core_ok = guard_wr_core_i && config_write_guard;
  assign guard_write_ok = guard_wr_ext_ok || guard_wr_core_ok;
  // An erase and a write in one cycle: the erase wins, the write is lost
  assign erase_go = erase_req && erase_allow;

  // Per-region guard bits; writes can only clear, erases only set
  genvar r;
  generate
    for (r = 0; r < `NUM_REGIONS; r = r + 1)
    begin : g_region
      // In a block erase, bits of a region outside the erase mask keep their value
      wire erase_hit;
      reg read_bit;
      reg write_bit;
      reg table_bit;
      assign erase_hit = erase_go && (ext_chip_erase_i || ext_erase_blocks_i[r]);
      assign block_read_guard[r] = read_bit;
      assign block_write_guard[r] = write_bit;
      assign block_table_read_guard[r] = table_bit;
      always @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          read_bit <= `GUARD_BIT_RESET;
          write_bit <= `GUARD_BIT_RESET;
          table_bit <= `GUARD_BIT_RESET;
        end
        else if (erase_hit)
        begin
          read_bit <= 1'b1;
          write_bit <= 1'b1;
          table_bit <= 1'b1;
        end
        else if (guard_write_ok && !erase_go)
        begin
          // A write only clears, so a 1 can never be written back
          read_bit <= read_bit & ~wr_read_guard_i[r];
          write_bit <= write_bit & ~wr_write_guard_i[r];
          table_bit <= table_bit & ~wr_table_read_guard_i[r];
        end
      end
    end
  endgenerate

  // EEPROM, config, low-voltage enable and debug bits
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      eeprom_read_guard <= 1'b1;
      eeprom_write_guard <= 1'b1;
      config_write_guard <= 1'b1;
      low_voltage_prog_enable <= `LVP_RESET;
      debug_bit <= `DEBUG_RESET;
    end
    else if (erase_go)
    begin
      // Only a full chip erase reaches the EEPROM and config guards
      if (ext_chip_erase_i)
      begin
        eeprom_read_guard <= 1'b1;
        eeprom_write_guard <= 1'b1;
        config_write_guard <= 1'b1;
      end
    end
    else if (guard_write_ok)
    begin
      eeprom_read_guard <= eeprom_read_guard & ~wr_misc_i[0];
      eeprom_write_guard <= eeprom_write_guard & ~wr_misc_i[1];
      // Core may not touch the config guard itself
      if (guard_wr_ext_ok)
        config_write_guard <= config_write_guard & ~wr_misc_i[2];
      // Low-voltage enable moves only with high voltage on master clear
      if (guard_wr_ext_ok && hv_mode_o && wr_lvp_i)
        low_voltage_prog_enable <= wr_lvp_val_i;
      if (wr_debug_i)
        debug_bit <= wr_debug_val_i;
    end
  end

  // Registered grants; each stands one cycle after its request
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tbl_rd_ok_o <= 1'b0;
      tbl_rdata_o <= 8'h00;
      tbl_wr_ok_o <= 1'b0;
      ext_rd_ok_o <= 1'b0;
      ext_wr_ok_o <= 1'b0;
      core_ee_rd_ok_o <= 1'b0;
      core_ee_wr_ok_o <= 1'b0;
      erase_ok_o <= 1'b0;
    end
    else
    begin
      tbl_rd_ok_o <= tbl_rd_i && tbl_rd_allow;
      tbl_rdata_o <= (tbl_rd_i && tbl_rd_allow) ? mem_rdata_i : 8'h00;
      tbl_wr_ok_o <= tbl_wr_i && tbl_wr_allow;
      ext_rd_ok_o <= ext_rd_i && prog_mode_o && ext_allow;
      ext_wr_ok_o <= ext_wr_i && prog_mode_o && ext_wr_allow;
      core_ee_rd_ok_o <= core_ee_rd_i;
      core_ee_wr_ok_o <= core_ee_wr_i && eeprom_write_guard;
      erase_ok_o <= erase_go ||
        (ext_row_erase_i && prog_mode_o && !row_blocked);
    end
  end

  // Mode levels and guard mirrors; mirrors trail the guard bits by a cycle
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prog_mode_o <= 1'b0;
      hv_mode_o <= 1'b0;
      pgm_pin_dedicated_o <= 1'b0;
      debug_enable_o <= 1'b0;
      block_read_guard_o <= `GUARDS_RESET;
      block_write_guard_o <= `GUARDS_RESET;
      block_table_read_guard_o <= `GUARDS_RESET;
      eeprom_read_guard_o <= 1'b1;
      eeprom_write_guard_o <= 1'b1;
      config_write_guard_o <= 1'b1;
    end
    else
    begin
      prog_mode_o <= hv_now || lv_now;
      hv_mode_o <= hv_now;
      pgm_pin_dedicated_o <= low_voltage_prog_enable;
      debug_enable_o <= !debug_bit;
      block_read_guard_o <= block_read_guard;
      block_write_guard_o <= block_write_guard;
      block_table_read_guard_o <= block_table_read_guard;
      eeprom_read_guard_o <= eeprom_read_guard;
      eeprom_write_guard_o <= eeprom_write_guard;
      config_write_guard_o <= config_write_guard;
    end
  end
endmodule // code_protection_unit
`default_nettype wire

// ---- tb/code_protection_properties.sv ----
// Port-level checks for the code protection unit
`timescale 1ns/1ns
`default_nettype none
module code_protection_properties (
  input wire logic clk_sys_i, rst_i, tbl_rd_i, tbl_wr_i, ext_rd_i, ext_eeprom_i,
  input wire logic ext_chip_erase_i, ext_block_erase_i, core_ee_wr_i, master_clear_hv_i,
  input wire logic [20:0] tbl_addr_i, exec_pc_i, ext_addr_i,
  input wire logic [7:0] mem_rdata_i, tbl_rdata_o,
  input wire logic tbl_rd_ok_o, tbl_wr_ok_o, ext_rd_ok_o, core_ee_wr_ok_o, prog_mode_o,
  input wire logic [4:0] block_read_guard_o, block_write_guard_o, block_table_read_guard_o,
  input wire logic eeprom_read_guard_o, eeprom_write_guard_o, config_write_guard_o
);
  reg [1:0] recent;
  wire [17:0] g = {block_read_guard_o, block_write_guard_o, block_table_read_guard_o,
    eeprom_read_guard_o, eeprom_write_guard_o, config_write_guard_o};
  // Region of an address, 7 outside user program memory
  function automatic [2:0] rg(input [20:0] a);
    rg = a < 21'h000800 ? 3'h0 : a < 21'h002000 ? 3'h1 : a < 21'h004000 ? 3'h2 :
      a < 21'h006000 ? 3'h3 : a < 21'h008000 ? 3'h4 : 3'h7;
  endfunction
  // Mirrors lag the real bits after an erase, so guard checks pause
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      recent <= 2'h0;
    else if (ext_chip_erase_i || ext_block_erase_i)
      recent <= 2'h3;
    else if (recent != 2'h0)
      recent <= recent - 2'h1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence hv_held;
    master_clear_hv_i [*5];
  endsequence
  guard_rise_erase_a: assert property (|(g & ~$past(g)) |-> recent != 2'h0)
    else $error("guard set without erase");
  same_block_read_a: assert property (tbl_rd_i && rg(tbl_addr_i) != 3'h7 &&
    rg(exec_pc_i) == rg(tbl_addr_i) |=> tbl_rd_ok_o && tbl_rdata_o == $past(mem_rdata_i))
    else $error("same block read refused");
  foreign_read_zero_a: assert property (tbl_rd_i && rg(tbl_addr_i) != 3'h7 &&
    recent == 2'h0 && rg(exec_pc_i) != rg(tbl_addr_i) &&
    !block_table_read_guard_o[rg(tbl_addr_i)] |=> !tbl_rd_ok_o && tbl_rdata_o == 8'h00)
    else $error("foreign read not zeroed");
  table_write_block_a: assert property (tbl_wr_i && rg(tbl_addr_i) != 3'h7 &&
    recent == 2'h0 && !block_write_guard_o[rg(tbl_addr_i)] |=> !tbl_wr_ok_o)
    else $error("guarded write granted");
  ext_read_block_a: assert property (ext_rd_i && !ext_eeprom_i && rg(ext_addr_i) != 3'h7 &&
    recent == 2'h0 && !block_read_guard_o[rg(ext_addr_i)] |=> !ext_rd_ok_o)
    else $error("guarded ext read granted");
  ee_ext_read_a: assert property (ext_rd_i && ext_eeprom_i && !eeprom_read_guard_o &&
    recent == 2'h0 |=> !ext_rd_ok_o) else $error("ext eeprom read granted");
  ee_core_write_a: assert property (core_ee_wr_i && !eeprom_write_guard_o &&
    recent == 2'h0 |=> !core_ee_wr_ok_o) else $error("core eeprom write granted");
  hv_entry_a: assert property (hv_held |-> prog_mode_o)
    else $error("high voltage entry missed");
endmodule // code_protection_properties
bind code_protection_unit code_protection_properties u_props (.*);
`default_nettype wire

// ---- tb/mem_model.sv ----
// Program memory and programmer entry pin stand-in
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  input wire logic [20:0] addr_i,
  input wire logic enter_i,
  output wire logic [7:0] data_o,
  output wire logic entry_pin_o
);
  // Address-keyed pattern so a misrouted byte shows up
  assign data_o = addr_i[7:0] ^ 8'h5a;
  // Programmer raises the entry pin to ask for programming mode, and
  // drives it low otherwise, so no port pull-up is left to lift it
  assign entry_pin_o = enter_i;
endmodule // mem_model
`default_nettype wire

// ---- tb/test_code_protection_unit.sv ----
// Directed bench for the code protection unit
`timescale 1ns/1ns
`default_nettype none
module test_code_protection_unit;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, ext_eeprom_i = 1'b0, master_clear_hv_i = 1'b0;
  logic wr_debug_i = 1'b0, enter = 1'b0, lvp_wr = 1'b0, lvp_val = 1'b0, dbg_val = 1'b0;
  logic [10:0] s = 11'h000;
  logic [20:0] tbl_addr_i = 21'h000000, exec_pc_i = 21'h000100;
  logic [4:0] ext_erase_blocks_i = 5'h00, wr_read_guard_i = 5'h00, wr_write_guard_i = 5'h00;
  logic [4:0] wr_table_read_guard_i = 5'h00;
  logic [2:0] wr_misc_i = 3'h0;
  wire [7:0] mem_rdata_i, tbl_rdata_o;
  wire program_entry_pin_i, tbl_rd_ok_o, tbl_wr_ok_o, ext_rd_ok_o, ext_wr_ok_o, erase_ok_o;
  wire core_ee_rd_ok_o, core_ee_wr_ok_o, prog_mode_o, hv_mode_o, pgm_pin_dedicated_o;
  wire debug_enable_o, eeprom_read_guard_o, eeprom_write_guard_o, config_write_guard_o;
  wire [4:0] block_read_guard_o, block_write_guard_o, block_table_read_guard_o;
  wire [7:0] misc_guards = {5'h00, eeprom_read_guard_o, eeprom_write_guard_o, config_write_guard_o};
  integer mismatches = 0, tests_run = 0, cycles = 0;
  mem_model u_mem (.addr_i(tbl_addr_i), .enter_i(enter), .data_o(mem_rdata_i),
    .entry_pin_o(program_entry_pin_i));
  // Strobes share one vector so a request is a single assignment
  code_protection_unit u_dut (.*, .ext_addr_i(tbl_addr_i), .tbl_rd_i(s[0]), .tbl_wr_i(s[1]),
    .ext_rd_i(s[2]), .ext_wr_i(s[3]), .core_ee_rd_i(s[4]), .core_ee_wr_i(s[5]),
    .ext_block_erase_i(s[6]), .ext_row_erase_i(s[7]), .guard_wr_ext_i(s[8]),
    .guard_wr_core_i(s[9]), .ext_chip_erase_i(s[10]), .wr_lvp_i(lvp_wr), .wr_lvp_val_i(lvp_val),
    .wr_debug_val_i(dbg_val));
  always #5 clk_sys_i = ~clk_sys_i;
  // Ceiling far above the fewer than a hundred cycles needed
  always @(posedge clk_sys_i)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  // One-cycle request; the answer is settled at the next falling edge
  task go(input [10:0] v, input [20:0] ad);
    @(negedge clk_sys_i);
    s = v;
    tbl_addr_i = ad;
    @(negedge clk_sys_i);
    s = 11'h000;
  endtask
  task chk1(input [8*7:1] nm, input e, input g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s exp %b got %b", nm, e, g);
    end
  endtask
  task chk8(input [8*7:1] nm, input [7:0] e, input [7:0] g);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk8("rgrd", 8'h1f, {3'h0, block_read_guard_o});
    chk1("dbg", 1'b0, debug_enable_o);
    go(11'h001, 21'h300008);
    chk8("cfgdata", 8'h52, tbl_rdata_o);
    chk1("lvpin", 1'b1, pgm_pin_dedicated_o);
    $display("test reset and config read done");
    master_clear_hv_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    chk1("hvprog", 1'b1, prog_mode_o);
    wr_read_guard_i = 5'h04;
    wr_write_guard_i = 5'h04;
    wr_table_read_guard_i = 5'h04;
    wr_misc_i = 3'h7;
    wr_debug_i = 1'b1;
    go(11'h100, 21'h000000);
    repeat (3) @(negedge clk_sys_i);
    chk8("tgrd", 8'h1b, {3'h0, block_table_read_guard_o});
    chk1("dbgon", 1'b1, debug_enable_o);
    chk8("wgrd", 8'h1b, {3'h0, block_write_guard_o});
    chk8("misc", 8'h00, misc_guards);
    chk1("hvmode", 1'b1, hv_mode_o);
    go(11'h001, 21'h002010);
    chk8("frdata", 8'h00, tbl_rdata_o);
    chk1("frok", 1'b0, tbl_rd_ok_o);
    go(11'h001, 21'h200003);
    chk8("iddata", 8'h59, tbl_rdata_o);
    exec_pc_i = 21'h002100;
    go(11'h001, 21'h002010);
    chk8("srdata", 8'h4a, tbl_rdata_o);
    chk1("srok", 1'b1, tbl_rd_ok_o);
    go(11'h002, 21'h002010);
    chk1("wrblk", 1'b0, tbl_wr_ok_o);
    go(11'h002, 21'h004010);
    chk1("wrok", 1'b1, tbl_wr_ok_o);
    go(11'h002, 21'h300008);
    chk1("cfgwr", 1'b0, tbl_wr_ok_o);
    go(11'h002, 21'h200003);
    chk1("idwr", 1'b1, tbl_wr_ok_o);
    go(11'h002, 21'h3ffffe);
    chk1("devwr", 1'b0, tbl_wr_ok_o);
    go(11'h004, 21'h002010);
    chk1("xrdblk", 1'b0, ext_rd_ok_o);
    ext_eeprom_i = 1'b1;
    go(11'h008, 21'h000010);
    chk1("xeewr", 1'b0, ext_wr_ok_o);
    go(11'h010, 21'h000010);
    chk1("ceerd", 1'b1, core_ee_rd_ok_o);
    go(11'h020, 21'h000010);
    chk1("ceewr", 1'b0, core_ee_wr_ok_o);
    ext_eeprom_i = 1'b0;
    $display("test guards done");
    go(11'h080, 21'h002010);
    chk1("rower", 1'b0, erase_ok_o);
    ext_erase_blocks_i = 5'h04;
    go(11'h040, 21'h002010);
    chk1("blker", 1'b1, erase_ok_o);
    repeat (3) @(negedge clk_sys_i);
    go(11'h004, 21'h002010);
    chk1("xrder", 1'b1, ext_rd_ok_o);
    chk8("wgrder", 8'h1f, {3'h0, block_write_guard_o});
    go(11'h008, 21'h002010);
    chk1("xwrer", 1'b1, ext_wr_ok_o);
    go(11'h200, 21'h000000);
    repeat (2) @(negedge clk_sys_i);
    chk8("coregw", 8'h1f, {3'h0, block_read_guard_o});
    $display("test erase done");
    master_clear_hv_i = 1'b0;
    enter = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    chk1("lvprog", 1'b1, prog_mode_o);
    $display("test low voltage entry done");
    master_clear_hv_i = 1'b1;
    lvp_wr = 1'b1;
    dbg_val = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    go(11'h100, 21'h000000);
    repeat (2) @(negedge clk_sys_i);
    chk1("lvpoff", 1'b0, pgm_pin_dedicated_o);
    chk1("dbgoff", 1'b0, debug_enable_o);
    go(11'h400, 21'h000000);
    repeat (2) @(negedge clk_sys_i);
    chk8("chiper", 8'h07, misc_guards);
    go(11'h020, 21'h000010);
    chk1("ceewrok", 1'b1, core_ee_wr_ok_o);
    master_clear_hv_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk1("lvgone", 1'b0, prog_mode_o);
    go(11'h400, 21'h000000);
    chk1("erno", 1'b0, erase_ok_o);
    $display("test low voltage disable and chip erase done");
    tally_and_finish;
  end
endmodule // test_code_protection_unit
`default_nettype wire
